// *** logic/psa_pkg.sv ***
// constants, register map and state type for the phy status, identifier and advert registers
// Summary of operation
// - status bit 5 shows negotiation complete
// - status bit 4 latches far-end fault high
// - status bit 2 link, latches low on loss
// - status bit 1 latches jabber high
// - status bits 14:11 read constant one
// - status bits 15, 10, 9 read zero
// - status bit 8 reads one: extended status
// - status bit 6 reads one: preamble suppression
// - status bit 3 reads one: negotiation able
// - status bit 0 reads one: extended registers
// - status bit 7 shows unidirectional fiber ability
// - identifier high holds org id bits 3-18
// - identifier low 15:10 holds org id 19-24
// - identifier low holds model and revision
// - advert bits 15, 13 writable, reset zero
// - advert pause bits writable, reset from straps
// - advert speed bits writable, reset from straps
// - advert bit 9 writable, resets zero
// - advert selector writable, resets to 00001
package psa_pkg;
   localparam logic [4:0]  REG_STATUS    = 5'h01;
   localparam logic [4:0]  REG_ID_HIGH   = 5'h02;
   localparam logic [4:0]  REG_ID_LOW    = 5'h03;
   localparam logic [4:0]  REG_ADVERT    = 5'h04;
   localparam logic [4:0]  REG_PAGE      = 5'h1f;
   localparam logic [15:0] PAGE_MAIN     = 16'h0000;
   localparam int          ST_T4         = 15;
   localparam int          ST_CAP_MSB    = 14;
   localparam int          ST_CAP_LSB    = 11;
   localparam int          ST_T2_FDX     = 10;
   localparam int          ST_T2_HDX     = 9;
   localparam int          ST_EXT_STATUS = 8;
   localparam int          ST_UNIDIR     = 7;
   localparam int          ST_PREAMBLE   = 6;
   localparam int          ST_AN_DONE    = 5;
   localparam int          ST_FAULT      = 4;
   localparam int          ST_AN_ABLE    = 3;
   localparam int          ST_LINK       = 2;
   localparam int          ST_JABBER     = 1;
   localparam int          ST_EXT_CAP    = 0;
   localparam int          ADV_NEXT_PAGE = 15;
   localparam int          ADV_RFAULT    = 13;
   localparam int          ADV_PAUSE_LSB = 10;
   localparam int          ADV_T4        = 9;
   localparam int          ADV_SPEED_LSB = 5;
   localparam logic [15:0] ADV_RESET     = 16'h0001;
   localparam logic [15:0] ADV_WR_MASK   = 16'hbfff;
   localparam logic [1:0]  OP_READ       = 2'b10;
   localparam logic [1:0]  OP_WRITE      = 2'b01;
   localparam logic [4:0]  HDR_LAST      = 5'h0b;
   localparam logic [4:0]  DATA_LAST     = 5'h0f;
   localparam logic [4:0]  SKIP_LAST     = 5'h11;
   localparam logic [2:0]  STRAP_SETTLE  = 3'h4;
   typedef enum logic [2:0] {
      PSA_IDLE  = 3'b000,
      PSA_START = 3'b001,
      PSA_HDR   = 3'b010,
      PSA_TURN  = 3'b011,
      PSA_DATA  = 3'b100,
      PSA_SKIP  = 3'b101
   } psa_state_e;
endpackage : psa_pkg

// *** logic/psa_regs.sv ***
// management register slave: mode status, identifiers and advertisement over mdc/mdio
`timescale 1ns/1ns
module psa_regs #(
   parameter logic [4:0]  PHY_ADDR   = 5'h00,
   parameter logic [21:0] ORG_ID     = 22'h2a5a5c, // arbitrary value
   parameter logic [5:0]  MODEL_NUM  = 6'h15,      // arbitrary value
   parameter logic [3:0]  REVISION   = 4'h3        // arbitrary value
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n,
   input  wire logic [5:0]  strap_config_pins,
   input  wire logic        link_up,
   input  wire logic        remote_fault,
   input  wire logic        jabber,
   input  wire logic        autoneg_complete,
   input  wire logic        unidir_able,
   output logic [15:0]      adv_ability
);
   import psa_pkg::*;

   logic [2:0]  mdc_s, mdio_s;
   logic [2:0]  next_mdc_s, next_mdio_s;
   logic [5:0]  strap_s1, strap_s2, strap_s3;
   logic        mdc_f, next_mdc_f;
   psa_state_e  state, next_state;
   logic [4:0]  cnt, next_cnt;
   logic [15:0] sh, next_sh;
   logic [4:0]  regad, next_regad;
   logic        is_read, next_is_read;
   logic        next_mdio_o, next_mdio_oe_n;
   logic [15:0] page, next_page;
   logic [15:0] next_adv;
   logic        fault_l, jabber_l, link_l;
   logic        next_fault_l, next_jabber_l, next_link_l;
   logic [2:0]  settle, next_settle;
   logic        strap_done, next_strap_done;
   logic        mdc_rise, bit_in, rd_status, wr_adv, strap_load;
   logic [11:0] hdr;
   logic [15:0] wr_data, status_word;

   // fixed bits plus live and latched flags
   always_comb begin
      status_word                          = '0;
      status_word[ST_CAP_MSB:ST_CAP_LSB]   = '1;
      status_word[ST_T4]                   = 1'b0;
      status_word[ST_T2_FDX]               = 1'b0;
      status_word[ST_T2_HDX]               = 1'b0;
      status_word[ST_EXT_STATUS]           = 1'b1;
      status_word[ST_UNIDIR]               = unidir_able;
      status_word[ST_PREAMBLE]             = 1'b1;
      status_word[ST_AN_DONE]              = autoneg_complete;
      status_word[ST_FAULT]                = fault_l;
      status_word[ST_AN_ABLE]              = 1'b1;
      status_word[ST_LINK]                 = link_l;
      status_word[ST_JABBER]               = jabber_l;
      status_word[ST_EXT_CAP]              = 1'b1;
   end

   // main-page registers answer only while the page register holds zero
   function automatic logic [15:0] read_word(input logic [4:0] ra, input logic [15:0] pg,
                                             input logic [15:0] st, input logic [15:0] adv);
      logic [15:0] w;
      w = 16'h0000;
      if (ra == REG_PAGE) begin
         w = pg;
      end else if (pg == PAGE_MAIN) begin
         unique case (ra)
            REG_STATUS:  w = st;
            REG_ID_HIGH: w = ORG_ID[21:6];
            REG_ID_LOW:  w = {ORG_ID[5:0], MODEL_NUM, REVISION};
            REG_ADVERT:  w = adv;
            default:     w = 16'h0000;
         endcase
      end
      return w;
   endfunction : read_word

   // a level counts once the second and third stages agree
   assign mdc_rise   = mdc_s[1] & mdc_s[2] & ~mdc_f;
   assign bit_in     = mdio_s[2];
   assign hdr        = {sh[10:0], bit_in};
   assign wr_data    = {sh[14:0], bit_in};
   assign rd_status  = mdc_rise && state == PSA_HDR && cnt == HDR_LAST
                       && hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_READ
                       && hdr[4:0] == REG_STATUS && page == PAGE_MAIN;
   assign wr_adv     = mdc_rise && state == PSA_DATA && !is_read && cnt == DATA_LAST
                       && regad == REG_ADVERT && page == PAGE_MAIN;
   assign strap_load = !strap_done && settle == STRAP_SETTLE;

   always_comb begin
      next_mdc_s      = {mdc_s[1:0], mdc};
      next_mdio_s     = {mdio_s[1:0], mdio_i};
      next_mdc_f      = (mdc_s[1] == mdc_s[2]) ? mdc_s[2] : mdc_f;
      next_state      = state;
      next_cnt        = cnt;
      next_sh         = sh;
      next_regad      = regad;
      next_is_read    = is_read;
      next_mdio_o     = mdio_o;
      next_mdio_oe_n  = mdio_oe_n;
      next_page       = page;
      next_adv        = adv_ability;
      next_settle     = settle;
      next_strap_done = strap_done;
      // a new event wins over the clear done by a status read
      next_fault_l    = remote_fault | (fault_l & ~rd_status);
      next_jabber_l   = jabber | (jabber_l & ~rd_status);
      next_link_l     = link_up & (link_l | rd_status);
      if (!strap_done && settle != STRAP_SETTLE) begin
         next_settle = settle + 3'h1;
      end
      // straps are taken once the synchroniser has filled after reset
      if (strap_load) begin
         next_strap_done                           = 1'b1;
         next_adv[ADV_PAUSE_LSB+1:ADV_PAUSE_LSB]   = strap_s3[5:4];
         next_adv[ADV_SPEED_LSB+3:ADV_SPEED_LSB]   = strap_s3[3:0];
      end
      if (mdc_rise) begin
         unique case (state)
            // preamble may be absent: any zero after idle ones starts a frame
            PSA_IDLE: begin
               if (!bit_in) begin
                  next_state = PSA_START;
               end
            end
            PSA_START: begin
               next_state = bit_in ? PSA_HDR : PSA_IDLE;
               next_cnt   = 5'h00;
            end
            PSA_HDR: begin
               next_sh  = {sh[14:0], bit_in};
               next_cnt = cnt + 5'h01;
               if (cnt == HDR_LAST) begin
                  next_regad = hdr[4:0];
                  next_cnt   = 5'h00;
                  if (hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_READ) begin
                     next_is_read = 1'b1;
                     next_sh      = read_word(hdr[4:0], page, status_word, adv_ability);
                     next_state   = PSA_TURN;
                  end else if (hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_WRITE) begin
                     next_is_read = 1'b0;
                     next_state   = PSA_TURN;
                  end else begin
                     next_state = PSA_SKIP;
                  end
               end
            end
            PSA_TURN: begin
               if (cnt == 5'h00) begin
                  next_cnt = 5'h01;
                  if (is_read) begin
                     next_mdio_o    = 1'b0;
                     next_mdio_oe_n = 1'b0;
                  end
               end else begin
                  next_cnt   = 5'h00;
                  next_state = PSA_DATA;
                  if (is_read) begin
                     next_mdio_o = sh[15];
                     next_sh     = {sh[14:0], 1'b0};
                  end
               end
            end
            PSA_DATA: begin
               next_cnt = cnt + 5'h01;
               if (is_read) begin
                  next_mdio_o = sh[15];
                  next_sh     = {sh[14:0], 1'b0};
                  if (cnt == DATA_LAST) begin
                     next_mdio_o    = 1'b0;
                     next_mdio_oe_n = 1'b1;
                     next_state     = PSA_IDLE;
                  end
               end else begin
                  next_sh = wr_data;
                  if (cnt == DATA_LAST) begin
                     next_state = PSA_IDLE;
                     if (regad == REG_PAGE) begin
                        next_page = wr_data;
                     end
                     if (wr_adv) begin
                        next_adv = (wr_data & ADV_WR_MASK) | (adv_ability & ~ADV_WR_MASK);
                     end
                  end
               end
            end
            // frames for other addresses are stepped over so their data cannot look like a start
            PSA_SKIP: begin
               next_cnt = cnt + 5'h01;
               if (cnt == SKIP_LAST) begin
                  next_state = PSA_IDLE;
               end
            end
            default: begin
               next_state = PSA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_s       <= 3'h0;
         mdio_s      <= 3'h7;
         strap_s1    <= 6'h00;
         strap_s2    <= 6'h00;
         strap_s3    <= 6'h00;
         mdc_f       <= 1'b0;
         state       <= PSA_IDLE;
         cnt         <= 5'h00;
         sh          <= 16'h0000;
         regad       <= 5'h00;
         is_read     <= 1'b0;
         mdio_o      <= 1'b0;
         mdio_oe_n   <= 1'b1;
         page        <= PAGE_MAIN;
         adv_ability <= ADV_RESET;
         fault_l     <= 1'b0;
         jabber_l    <= 1'b0;
         link_l      <= 1'b0;
         settle      <= 3'h0;
         strap_done  <= 1'b0;
      end else begin
         mdc_s       <= next_mdc_s;
         mdio_s      <= next_mdio_s;
         strap_s1    <= strap_config_pins;
         strap_s2    <= strap_s1;
         strap_s3    <= strap_s2;
         mdc_f       <= next_mdc_f;
         state       <= next_state;
         cnt         <= next_cnt;
         sh          <= next_sh;
         regad       <= next_regad;
         is_read     <= next_is_read;
         mdio_o      <= next_mdio_o;
         mdio_oe_n   <= next_mdio_oe_n;
         page        <= next_page;
         adv_ability <= next_adv;
         fault_l     <= next_fault_l;
         jabber_l    <= next_jabber_l;
         link_l      <= next_link_l;
         settle      <= next_settle;
         strap_done  <= next_strap_done;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence adv_write_s;
      wr_adv;
   endsequence
   sequence strap_take_s;
      strap_load;
   endsequence

   an_done_a: assert property (status_word[ST_AN_DONE] == autoneg_complete)
      else $error("complete bit does not follow negotiation");
   // a held bit may only change in the cycle after a status read released it
   fault_hold_a: assert property (remote_fault |=> status_word[ST_FAULT]
                                  ##1 (status_word[ST_FAULT] || $past(rd_status)))
      else $error("far-end fault not held");
   link_drop_a: assert property (!link_up |=> !status_word[ST_LINK]
                                 ##1 (!link_l || $past(rd_status)))
      else $error("link loss not latched low");
   jabber_hold_a: assert property (jabber |=> jabber_l ##1 (jabber_l || $past(rd_status)))
      else $error("jabber not held");
   caps_set_a: assert property (status_word[ST_CAP_MSB:ST_CAP_LSB] == 4'hf)
      else $error("speed capability bits not set");
   caps_clear_a: assert property (!status_word[ST_T4] && !status_word[ST_T2_FDX] && !status_word[ST_T2_HDX])
      else $error("absent abilities reported");
   ext_status_a: assert property (status_word[ST_EXT_STATUS])
      else $error("extended status bit clear");
   preamble_sup_a: assert property (state == PSA_IDLE && mdc_rise && !bit_in |=> state == PSA_START)
      else $error("suppressed preamble frame not started");
   an_able_a: assert property (status_word[ST_AN_ABLE] && status_word[ST_EXT_CAP])
      else $error("negotiation or extended capability bit clear");
   unidir_a: assert property (status_word[ST_UNIDIR] == unidir_able)
      else $error("unidirectional bit wrong");
   id_words_a: assert property (read_word(REG_ID_HIGH, PAGE_MAIN, status_word, adv_ability)
                                == ORG_ID[21:6])
      else $error("identifier high wrong");
   id_low_a: assert property (read_word(REG_ID_LOW, PAGE_MAIN, status_word, adv_ability)
                              == {ORG_ID[5:0], MODEL_NUM, REVISION})
      else $error("identifier low wrong");
   adv_write_a: assert property (adv_write_s |=> adv_ability[ADV_NEXT_PAGE] == $past(wr_data[ADV_NEXT_PAGE])
                                 && adv_ability[ADV_RFAULT] == $past(wr_data[ADV_RFAULT])
                                 && adv_ability[ADV_T4] == $past(wr_data[ADV_T4]))
      else $error("advert write not stored");
   strap_take_a: assert property (strap_take_s |=> adv_ability[ADV_PAUSE_LSB+1:ADV_PAUSE_LSB]
                                  == $past(strap_s3[5:4]) ##0
                                  adv_ability[ADV_SPEED_LSB+3:ADV_SPEED_LSB] == $past(strap_s3[3:0]))
      else $error("strap values not loaded");
   adv_reset_a: assert property ($past(settle) == 3'h0 && settle == 3'h1 |->
                                 adv_ability[4:0] == ADV_RESET[4:0] && !adv_ability[ADV_T4])
      else $error("advert reset value wrong");
   status_rel_a: assert property (rd_status && !jabber && !remote_fault |=> !jabber_l && !fault_l)
      else $error("status read did not release latches");
endmodule : psa_regs

// *** sim/psa_smc_model.sv ***
// station management controller model: drives mdc and frames on the management data line
`timescale 1ns/1ns
module psa_smc_model (
   input  wire logic ref_clk,
   input  wire logic mdio_line,
   output logic      mdc,
   output logic      host_d,
   output logic      host_en
);
   import psa_pkg::*;

   initial begin
      mdc     = 1'b0;
      host_d  = 1'b1;
      host_en = 1'b0;
   end

   // 10 ref_clk low then 10 high; the device synchroniser needs at least 2 each
   task automatic bit_cycle(input logic drive, input logic b, output logic seen);
      @(negedge ref_clk);
      mdc     = 1'b0;
      host_en = drive;
      host_d  = b;
      repeat (10) @(negedge ref_clk);
      mdc  = 1'b1;
      seen = mdio_line;
      repeat (9) @(negedge ref_clk);
   endtask : bit_cycle

   // mdc stands still low between frames; a released line is pulled up
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic        s;
      logic        rdop;
      hdr  = {2'b01, op, phy, ra};
      rdop = (op == OP_READ);
      rd   = 16'h0000;
      for (int i = 0; i < 2; i++) bit_cycle(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
      bit_cycle(!rdop, 1'b1, s);
      bit_cycle(!rdop, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cycle(!rdop, wd[i], s);
         rd[i] = s;
      end
      @(negedge ref_clk);
      host_en = 1'b0;
      mdc     = 1'b0;
   endtask : frame

   task automatic main_page(input logic [4:0] phy);
      logic [15:0] dummy;
      frame(OP_WRITE, phy, REG_PAGE, PAGE_MAIN, dummy);
   endtask : main_page
endmodule : psa_smc_model

// *** sim/phy_status_id_advert_regs_test.sv ***
// self-checking bench for the status, identifier and advertisement registers
`timescale 1ns/1ns
module phy_status_id_advert_regs_test;
   import psa_pkg::*;
   localparam logic [4:0]  PHY    = 5'h06;
   localparam logic [21:0] ORG    = 22'h1b3c2d; // arbitrary value
   localparam logic [5:0]  MODEL  = 6'h2a;      // arbitrary value
   localparam logic [3:0]  REV    = 4'h9;       // arbitrary value
   localparam logic [5:0]  STRAPS = 6'h2d;
   localparam logic [15:0] ADV0   = {4'h0, STRAPS[5:4], 1'b0, STRAPS[3:0], 5'h01};
   logic        ref_clk;
   logic        rst_n;
   logic        mdc;
   logic        mdio_o;
   logic        mdio_oe_n;
   logic        host_d;
   logic        host_en;
   logic        mdio_line;
   logic        link_up;
   logic        remote_fault;
   logic        jabber;
   logic        autoneg_complete;
   logic        unidir_able;
   logic [15:0] adv_ability;
   logic [15:0] rd;
   int          err_count;
   int          checked;

   // open-drain line with pull-up: device wins while enabled, else host, else high
   assign mdio_line = !mdio_oe_n ? mdio_o : (host_en ? host_d : 1'b1);

   psa_regs #(.PHY_ADDR(PHY), .ORG_ID(ORG), .MODEL_NUM(MODEL), .REVISION(REV)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o),
      .mdio_oe_n(mdio_oe_n), .strap_config_pins(STRAPS), .link_up(link_up),
      .remote_fault(remote_fault), .jabber(jabber), .autoneg_complete(autoneg_complete),
      .unidir_able(unidir_able), .adv_ability(adv_ability));

   psa_smc_model smc (.ref_clk(ref_clk), .mdio_line(mdio_line), .mdc(mdc), .host_d(host_d),
                      .host_en(host_en));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] st(logic lk, logic ft, logic an, logic jb, logic un);
      return {1'b0, 4'hf, 2'b00, 1'b1, un, 1'b1, an, ft, 1'b1, lk, jb, 1'b1};
   endfunction : st

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic rdreg(input logic [4:0] ra, output logic [15:0] d);
      smc.frame(OP_READ, PHY, ra, 16'h0000, d);
   endtask : rdreg

   task automatic wrreg(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] dummy;
      smc.frame(OP_WRITE, phy, ra, d, dummy);
   endtask : wrreg

   task automatic pulse_events();
      @(negedge ref_clk);
      link_up      = 1'b0;
      remote_fault = 1'b1;
      jabber       = 1'b1;
      @(negedge ref_clk);
      link_up      = 1'b1;
      remote_fault = 1'b0;
      jabber       = 1'b0;
   endtask : pulse_events

   task automatic t_reset_values();
      rdreg(REG_STATUS, rd);
      check("status after reset", st(1'b0, 1'b0, 1'b0, 1'b0, 1'b1), rd);
      rdreg(REG_ADVERT, rd);
      check("advert after reset", ADV0, rd);
      check("advert port after reset", ADV0, adv_ability);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_identifiers();
      rdreg(REG_ID_HIGH, rd);
      check("identifier high", ORG[21:6], rd);
      rdreg(REG_ID_LOW, rd);
      check("identifier low", {ORG[5:0], MODEL, REV}, rd);
      $display("test identifiers done");
   endtask : t_identifiers

   task automatic t_latches();
      @(negedge ref_clk);
      autoneg_complete = 1'b1;
      rdreg(REG_STATUS, rd);
      check("status link up", st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1), rd);
      pulse_events();
      rdreg(REG_STATUS, rd);
      check("status latched events", st(1'b0, 1'b1, 1'b1, 1'b1, 1'b1), rd);
      rdreg(REG_STATUS, rd);
      check("status after release", st(1'b1, 1'b0, 1'b1, 1'b0, 1'b1), rd);
      @(negedge ref_clk);
      autoneg_complete = 1'b0;
      unidir_able      = 1'b0;
      rdreg(REG_STATUS, rd);
      check("status negotiation idle", st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0), rd);
      $display("test latches done");
   endtask : t_latches

   task automatic t_advert_write();
      wrreg(PHY, REG_ADVERT, 16'hffff);
      check("advert port all ones", 16'hbfff, adv_ability);
      rdreg(REG_ADVERT, rd);
      check("advert read all ones", 16'hbfff, rd);
      wrreg(PHY, REG_ADVERT, 16'h0000);
      rdreg(REG_ADVERT, rd);
      check("advert read zero", 16'h0000, rd);
      $display("test advert_write done");
   endtask : t_advert_write

   task automatic t_refusals();
      wrreg(PHY ^ 5'h01, REG_ADVERT, 16'h1234);
      check("advert other phy", 16'h0000, adv_ability);
      wrreg(PHY, REG_STATUS, 16'h0000);
      rdreg(REG_STATUS, rd);
      check("status read only", st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0), rd);
      // a nonzero advert lets a blocked read or write be told apart
      wrreg(PHY, REG_ADVERT, 16'h0421);
      check("advert before page change", 16'h0421, adv_ability);
      wrreg(PHY, REG_PAGE, 16'h0001);
      rdreg(REG_PAGE, rd);
      check("page register", 16'h0001, rd);
      rdreg(REG_ADVERT, rd);
      check("advert off main page", 16'h0000, rd);
      wrreg(PHY, REG_ADVERT, 16'h00e1);
      smc.main_page(PHY);
      check("advert write off page", 16'h0421, adv_ability);
      $display("test refusals done");
   endtask : t_refusals

   initial begin
      rst_n            = 1'b0;
      link_up          = 1'b1;
      remote_fault     = 1'b0;
      jabber           = 1'b0;
      autoneg_complete = 1'b0;
      unidir_able      = 1'b1;
      err_count        = 0;
      checked          = 0;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      // straps settle five edges after release; stay clear of that window
      repeat (20) @(negedge ref_clk);
      smc.main_page(PHY);
      t_reset_values();
      t_identifiers();
      t_latches();
      t_advert_write();
      t_refusals();
      stop_test();
   end

   // about 22 frames of 700 cycles each are expected
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      stop_test();
   end
endmodule : phy_status_id_advert_regs_test
